//--- hw/adcc_top.sv
// converter mux and conversion control: registers, reference/channel latching, triggers, completion flag
//
// Functional notes
// - channel code 1111 routes and enables the temperature sensor single-ended
// - reference bits select supply, external pin, 1.1V, reserved or 2.56V options
// - reference written mid-conversion takes effect only after completion
// - conversion after any reference change lasts 25 converter clocks
// - left-adjust changes presented result immediately, even mid-conversion
// - codes 0-3 single-ended, 4-11 differential (odd codes with gain), 12 bandgap, 13 ground
// - codes 0100, 0101, 1000, 1001 give offset measurement
// - channel written mid-conversion takes effect only after completion
// - enable powers converter; clearing it aborts a running conversion
// - start bit begins single conversion or first conversion of free run
// - first conversion after enabling takes 25 converter clocks, later ones 13 unless the reference changed
// - start bit reads one while converting; writing zero does nothing
// - auto-trigger starts a conversion on a rising trigger edge; an edge while converting is dropped
// - completion flag sets when conversion ends and result is loaded
// - flag clears on interrupt vector acknowledge or software write of one
// - interrupt requested only with flag, local enable and global enable
// - prescaler divides system clock by 2 to 128
// - trigger on rising source flag; selecting free run triggers nothing
// - left adjust puts result in upper bits, else right adjusted
//
// Decided for this implementation: the plain strobed port.
`include "adcc_defs.svh"

module adcc_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [9:0] sample_in,
    input wire logic trigger_flag,
    input wire logic trigger_free_run,
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    output logic [7:0] result_high,
    output logic [7:0] result_low,
    output logic irq,
    output logic conv_power,
    output adcc_pkg::adcc_ref_e vref_src,
    output logic ext_ref_pin_en,
    output logic [3:0] analog_channel,
    output logic analog_diff,
    output logic analog_gain20,
    output logic offset_cal,
    output logic temp_sensor_en,
    output logic bandgap_sel,
    output logic ground_sel
);
    import adcc_pkg::*;

    adcc_conv_if conv ();

    adcc_prescaler u_prescaler (
        .clk(clk),
        .rst(rst),
        .conv(conv.clkgen)
    );

    adcc_sequencer u_sequencer (
        .clk(clk),
        .rst(rst),
        .conv(conv.seq)
    );

    logic en_q, start_q, auto_q, flag_q, ie_q;
    logic [2:0] ps_q;
    logic [2:0] ref_q;
    logic adj_q;
    logic [3:0] chan_q;
    logic [2:0] act_ref_q;
    logic [3:0] act_chan_q;
    logic init_pend_q, ref_pend_q, trig_prev_q;
    logic [9:0] raw_q;
    logic [7:0] res_hi_q, res_lo_q, rdata_q;
    logic irq_q, power_q, ext_pin_q, diff_q, gain_q, offs_q, temp_q, bg_q, gnd_q;
    adcc_ref_e vref_q;

    logic wr_ctrl, wr_mux, en_d, enabling, trig_rise, free_again, req, launch, hold, adj_d;
    logic [2:0] new_ref, act_ref_d;
    logic [3:0] act_chan_d;
    logic [9:0] raw_d;
    logic [15:0] aligned;

    assign wr_ctrl = wr && (addr == `ADCC_ADDR_CTRL);
    assign wr_mux = wr && (addr == `ADCC_ADDR_MUX);
    assign new_ref = {wdata[`ADCC_MUX_REF2], wdata[`ADCC_MUX_REF1], wdata[`ADCC_MUX_REF0]};
    assign en_d = wr_ctrl ? wdata[`ADCC_CTRL_EN] : en_q;
    assign enabling = wr_ctrl && wdata[`ADCC_CTRL_EN] && !en_q;
    // free run has no edge path
    assign trig_rise = auto_q && !trigger_free_run && trigger_flag && !trig_prev_q;
    assign free_again = auto_q && trigger_free_run && conv.done;
    assign req = (wr_ctrl && wdata[`ADCC_CTRL_START]) || trig_rise || free_again;
    // a trigger while busy is dropped, not queued
    assign launch = en_d && req && (!start_q || conv.done);
    assign hold = start_q && !conv.done;
    assign act_ref_d = hold ? act_ref_q : ref_q;
    assign act_chan_d = hold ? act_chan_q : chan_q;
    assign adj_d = wr_mux ? wdata[`ADCC_MUX_ADJ] : adj_q;
    assign raw_d = conv.done ? sample_in : raw_q;

    assign conv.powered = en_d;
    assign conv.prescale = ps_q;
    assign conv.launch = launch;
    assign conv.long_conv = init_pend_q || enabling || ref_pend_q;

    function automatic adcc_ref_e ref_decode(input logic [2:0] code);
        // upper bit ignored for low pairs 00 and 01
        if (code[1:0] == 2'b00) begin
            ref_decode = ADCC_REF_SUPPLY;
        end else if (code[1:0] == 2'b01) begin
            ref_decode = ADCC_REF_EXTERNAL;
        end else begin
            ref_decode = adcc_ref_e'(code);
        end
    endfunction : ref_decode

    always_comb begin
        if (adj_d) begin
            aligned = {raw_d, 6'h00};
        end else begin
            aligned = {6'h00, raw_d};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q <= 1'b0;
            auto_q <= 1'b0;
            ie_q <= 1'b0;
            ps_q <= 3'h0;
        end else if (wr_ctrl) begin
            en_q <= wdata[`ADCC_CTRL_EN];
            auto_q <= wdata[`ADCC_CTRL_AUTO];
            ie_q <= wdata[`ADCC_CTRL_IE];
            ps_q <= wdata[`ADCC_CTRL_PS_HI:`ADCC_CTRL_PS_LO];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_q <= 3'h0;
            adj_q <= 1'b0;
            chan_q <= 4'h0;
        end else if (wr_mux) begin
            ref_q <= new_ref;
            adj_q <= wdata[`ADCC_MUX_ADJ];
            chan_q <= wdata[`ADCC_MUX_CH_HI:`ADCC_MUX_CH_LO];
        end
    end

    // start clears with the result load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_q <= 1'b0;
        end else if (!en_d) begin
            start_q <= 1'b0;
        end else if (launch) begin
            start_q <= 1'b1;
        end else if (conv.done) begin
            start_q <= 1'b0;
        end
    end

    // cleared by ack or write of one; set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (conv.done) begin
            flag_q <= 1'b1;
        end else if ((wr_ctrl && wdata[`ADCC_CTRL_FLAG]) || irq_vector_ack) begin
            flag_q <= 1'b0;
        end
    end

    // reference change marked for the next conversion; marking wins over consumption
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_pend_q <= 1'b0;
            init_pend_q <= 1'b0;
        end else begin
            if (wr_mux && (new_ref != ref_q)) begin
                ref_pend_q <= 1'b1;
            end else if (launch) begin
                ref_pend_q <= 1'b0;
            end
            if (!en_d || launch) begin
                init_pend_q <= 1'b0;
            end else if (enabling) begin
                init_pend_q <= 1'b1;
            end
        end
    end

    // trigger history kept even in free run so returning to a source sees no stale edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= trigger_flag;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            raw_q <= 10'h000;
            res_hi_q <= 8'h00;
            res_lo_q <= 8'h00;
        end else begin
            raw_q <= raw_d;
            res_hi_q <= aligned[15:8];
            res_lo_q <= aligned[7:0];
        end
    end

    // analog routing from the selections in force
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_ref_q <= 3'h0;
            act_chan_q <= 4'h0;
            vref_q <= ADCC_REF_SUPPLY;
            ext_pin_q <= 1'b0;
            diff_q <= 1'b0;
            gain_q <= 1'b0;
            offs_q <= 1'b0;
            temp_q <= 1'b0;
            bg_q <= 1'b0;
            gnd_q <= 1'b0;
            power_q <= 1'b0;
        end else begin
            act_ref_q <= act_ref_d;
            act_chan_q <= act_chan_d;
            power_q <= en_d;
            vref_q <= ref_decode(act_ref_d);
            ext_pin_q <= (act_ref_d[1:0] == 2'b01) || (act_ref_d == 3'b111);
            diff_q <= (act_chan_d >= `ADCC_CH_DIFF_FIRST) && (act_chan_d <= `ADCC_CH_DIFF_LAST);
            gain_q <= (act_chan_d >= `ADCC_CH_DIFF_FIRST) && (act_chan_d <= `ADCC_CH_DIFF_LAST) && act_chan_d[0];
            offs_q <= (act_chan_d[3:1] == 3'b010) || (act_chan_d[3:1] == 3'b100);
            temp_q <= (act_chan_d == `ADCC_CH_TEMP);
            bg_q <= (act_chan_d == `ADCC_CH_BANDGAP);
            gnd_q <= (act_chan_d == `ADCC_CH_GROUND);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_q && ie_q && global_irq_enable;
        end
    end

    // unmapped reads and idle cycles return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (rd && (addr == `ADCC_ADDR_CTRL)) begin
            rdata_q <= {en_q, start_q, auto_q, flag_q, ie_q, ps_q};
        end else if (rd && (addr == `ADCC_ADDR_MUX)) begin
            rdata_q <= {ref_q[1], ref_q[0], adj_q, ref_q[2], chan_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata = rdata_q;
    assign result_high = res_hi_q;
    assign result_low = res_lo_q;
    assign irq = irq_q;
    assign conv_power = power_q;
    assign vref_src = vref_q;
    assign ext_ref_pin_en = ext_pin_q;
    assign analog_channel = act_chan_q;
    assign analog_diff = diff_q;
    assign analog_gain20 = gain_q;
    assign offset_cal = offs_q;
    assign temp_sensor_en = temp_q;
    assign bandgap_sel = bg_q;
    assign ground_sel = gnd_q;

    sequence s_disable;
        wr_ctrl && !wdata[`ADCC_CTRL_EN];
    endsequence

    sequence s_done_single;
        conv.done && !free_again && !launch;
    endsequence

    property p_temp;
        @(posedge clk) disable iff (rst)
        (analog_channel == `ADCC_CH_TEMP) |-> temp_sensor_en && !analog_diff && !offset_cal;
    endproperty
    a_temp: assert property (p_temp) else $error("temperature channel without sensor enable");

    property p_ref_low;
        @(posedge clk) disable iff (rst)
        (act_ref_q[1:0] == 2'b00) |-> (vref_src == ADCC_REF_SUPPLY) && !ext_ref_pin_en;
    endproperty
    a_ref_low: assert property (p_ref_low) else $error("supply reference not decoded");

    property p_ref_hold;
        @(posedge clk) disable iff (rst)
        (start_q && !conv.done) |=> $stable(act_ref_q) && $stable(analog_channel);
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("selection changed during conversion");

    sequence s_ref_change;
        wr_mux && (new_ref != ref_q);
    endsequence

    // marked even mid-conversion so the conversion after it is the long one
    property p_long_after_ref;
        @(posedge clk) disable iff (rst)
        s_ref_change |=> ref_pend_q && conv.long_conv;
    endproperty
    a_long_after_ref: assert property (p_long_after_ref) else $error("long length not marked");

    property p_abort;
        @(posedge clk) disable iff (rst)
        s_disable |=> !start_q && !conv.busy && !conv_power;
    endproperty
    a_abort: assert property (p_abort) else $error("disable did not abort");

    property p_start_reads;
        @(posedge clk) disable iff (rst)
        launch |=> start_q && conv.busy;
    endproperty
    a_start_reads: assert property (p_start_reads) else $error("start bit not set by launch");

    property p_complete;
        @(posedge clk) disable iff (rst)
        s_done_single |=> flag_q && !start_q && (raw_q == $past(sample_in));
    endproperty
    a_complete: assert property (p_complete) else $error("completion not reflected together");

    property p_irq;
        @(posedge clk) disable iff (rst)
        ##1 (irq == $past(flag_q && ie_q && global_irq_enable));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request not gated by flag and enables");

    property p_ack_clears;
        @(posedge clk) disable iff (rst)
        (irq_vector_ack && !conv.done) |=> !flag_q;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("flag survived acknowledge");

    property p_adjust_now;
        @(posedge clk) disable iff (rst)
        (wr_mux && wdata[`ADCC_MUX_ADJ] && !conv.done) |=> (result_low[5:0] == 6'h00) && (result_high == raw_q[9:2]);
    endproperty
    a_adjust_now: assert property (p_adjust_now) else $error("left adjust not applied at once");
endmodule : adcc_top

//--- hw/adcc_defs.svh
// register map, field positions, reset values and conversion lengths of the converter control
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

`define ADCC_ADDR_CTRL 8'h06
`define ADCC_ADDR_MUX 8'h07

`define ADCC_CTRL_RESET 8'h00
`define ADCC_MUX_RESET 8'h00

`define ADCC_CTRL_EN 7
`define ADCC_CTRL_START 6
`define ADCC_CTRL_AUTO 5
`define ADCC_CTRL_FLAG 4
`define ADCC_CTRL_IE 3
`define ADCC_CTRL_PS_HI 2
`define ADCC_CTRL_PS_LO 0

`define ADCC_MUX_REF1 7
`define ADCC_MUX_REF0 6
`define ADCC_MUX_ADJ 5
`define ADCC_MUX_REF2 4
`define ADCC_MUX_CH_HI 3
`define ADCC_MUX_CH_LO 0

`define ADCC_CONV_LONG 5'd25
`define ADCC_CONV_SHORT 5'd13

`define ADCC_CH_DIFF_FIRST 4'h4
`define ADCC_CH_DIFF_LAST 4'hb
`define ADCC_CH_BANDGAP 4'hc
`define ADCC_CH_GROUND 4'hd
`define ADCC_CH_TEMP 4'hf

`endif

//--- hw/adcc_pkg.sv
// types shared by the converter control modules
package adcc_pkg;
    typedef enum logic [2:0] {
        ADCC_REF_SUPPLY = 3'b000,
        ADCC_REF_EXTERNAL = 3'b001,
        ADCC_REF_INT_1V1 = 3'b010,
        ADCC_REF_RESERVED = 3'b011,
        ADCC_REF_INT_2V56 = 3'b110,
        ADCC_REF_INT_2V56_BYP = 3'b111
    } adcc_ref_e;

    typedef enum logic {
        ADCC_SEQ_IDLE = 1'b0,
        ADCC_SEQ_CONV = 1'b1
    } adcc_seq_e;
endpackage : adcc_pkg

//--- hw/adcc_conv_if.sv
// signals between register logic, converter clock prescaler and conversion sequencer
interface adcc_conv_if;
    logic powered;
    logic [2:0] prescale;
    logic tick;
    logic launch;
    logic long_conv;
    logic busy;
    logic done;

    modport ctrl (output powered, output prescale, output launch, output long_conv, input busy, input done);
    modport clkgen (input powered, input prescale, output tick);
    modport seq (input powered, input tick, input launch, input long_conv, output busy, output done);
endinterface : adcc_conv_if

//--- hw/adcc_prescaler.sv
// converter clock prescaler: one-cycle tick every 2..128 system clocks
module adcc_prescaler (
    input wire logic clk,
    input wire logic rst,
    adcc_conv_if.clkgen conv
);
    import adcc_pkg::*;

    logic [6:0] div_cnt_q;
    logic [6:0] div_last;
    logic tick_q;

    always_comb begin
        if (conv.prescale == 3'h0) begin
            div_last = 7'h01;
        end else begin
            div_last = 7'((8'h01 << conv.prescale) - 8'h01);
        end
    end

    // >= rather than == so a smaller code written mid-count cannot overrun
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_q <= 7'h00;
            tick_q <= 1'b0;
        end else if (!conv.powered) begin
            div_cnt_q <= 7'h00;
            tick_q <= 1'b0;
        end else if (div_cnt_q >= div_last) begin
            div_cnt_q <= 7'h00;
            tick_q <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 7'h01;
            tick_q <= 1'b0;
        end
    end

    assign conv.tick = tick_q;
endmodule : adcc_prescaler

//--- hw/adcc_sequencer.sv
// conversion sequencer: counts converter clock ticks, pulses done at the end
`include "adcc_defs.svh"

module adcc_sequencer (
    input wire logic clk,
    input wire logic rst,
    adcc_conv_if.seq conv
);
    import adcc_pkg::*;

    adcc_seq_e state_q;
    logic [4:0] cnt_q;
    logic [4:0] len_q;
    logic done_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ADCC_SEQ_IDLE;
            cnt_q <= 5'h00;
            len_q <= `ADCC_CONV_SHORT;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!conv.powered) begin
                state_q <= ADCC_SEQ_IDLE;
                cnt_q <= 5'h00;
            end else if (conv.launch) begin
                state_q <= ADCC_SEQ_CONV;
                cnt_q <= 5'h00;
                len_q <= conv.long_conv ? `ADCC_CONV_LONG : `ADCC_CONV_SHORT;
            end else begin
                unique case (state_q)
                    ADCC_SEQ_IDLE: begin
                        cnt_q <= 5'h00;
                    end
                    ADCC_SEQ_CONV: begin
                        if (conv.tick) begin
                            if (cnt_q == len_q - 5'h01) begin
                                state_q <= ADCC_SEQ_IDLE;
                                done_q <= 1'b1;
                            end else begin
                                cnt_q <= cnt_q + 5'h01;
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign conv.busy = (state_q == ADCC_SEQ_CONV);
    assign conv.done = done_q;

    property p_len_end;
        @(posedge clk) disable iff (rst)
        (state_q == ADCC_SEQ_CONV) && conv.tick && (cnt_q == len_q - 5'h01) && conv.powered && !conv.launch
            |=> done_q && (state_q == ADCC_SEQ_IDLE);
    endproperty
    a_len_end: assert property (p_len_end) else $error("conversion did not end after its length");
endmodule : adcc_sequencer

//--- verif/tb.sv
// self-checking bench for the converter mux and conversion control
`include "adcc_defs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adcc_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [9:0] sample_in = 10'h000;
    logic trigger_flag = 1'b0;
    logic trigger_free_run = 1'b0;
    logic global_irq_enable = 1'b0;
    logic irq_vector_ack = 1'b0;
    logic [7:0] rdata, result_high, result_low;
    logic irq, conv_power, ext_ref_pin_en, analog_diff, analog_gain20;
    logic offset_cal, temp_sensor_en, bandgap_sel, ground_sel;
    logic [3:0] analog_channel;
    adcc_ref_e vref_src;
    int err_total = 0;
    int samples_checked = 0;
    integer seed = 51935;
    logic [7:0] v;
    logic [9:0] s;
    int n;

    adcc_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .sample_in(sample_in), .trigger_flag(trigger_flag), .trigger_free_run(trigger_free_run),
        .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack), .result_high(result_high),
        .result_low(result_low), .irq(irq), .conv_power(conv_power), .vref_src(vref_src),
        .ext_ref_pin_en(ext_ref_pin_en), .analog_channel(analog_channel), .analog_diff(analog_diff),
        .analog_gain20(analog_gain20), .offset_cal(offset_cal), .temp_sensor_en(temp_sensor_en),
        .bandgap_sel(bandgap_sel), .ground_sel(ground_sel));

    initial begin
        forever #2 clk = ~clk;
    end

    function automatic logic [2:0] exp_ref(input logic [2:0] r);
        if (r[1:0] == 2'b00) return 3'b000;
        if (r[1:0] == 2'b01) return 3'b001;
        return r;
    endfunction : exp_ref

    // {diff, gain20, offset, temp, bandgap, ground}
    function automatic logic [5:0] exp_chan(input logic [3:0] c);
        logic d;
        d = (c >= 4'h4) && (c <= 4'hb);
        return {d, d & c[0], c == 4'h4 || c == 4'h5 || c == 4'h8 || c == 4'h9, c == 4'hf, c == 4'hc, c == 4'hd};
    endfunction : exp_chan

    function automatic int exp_div(input logic [2:0] p);
        return (p < 3'd2) ? 2 : (1 << p);
    endfunction : exp_div

    task automatic results();
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({12'h0, rdata}, {12'h0, exp});
    endtask : rd_chk

    // bounded wait for the interrupt line, cycles counted from the call
    task automatic wait_irq(output int cnt);
        cnt = 0;
        #1;
        while (irq !== 1'b1 && cnt < 8000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (cnt >= 8000) begin
            err_total++;
            results();
        end
    endtask : wait_irq

    // converter clock runs free, so a start waits up to one divided period for its first tick
    task automatic rng(input int got, input int lo, input int div);
        chk(20'((got >= lo - div + 3 && got <= lo + 2) ? lo : got), 20'(lo));
    endtask : rng

    task automatic ack();
        @(posedge clk);
        irq_vector_ack <= 1'b1;
        @(posedge clk);
        irq_vector_ack <= 1'b0;
    endtask : ack

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({conv_power, irq, vref_src, analog_channel, result_high}, 20'h0);
        rd_chk(`ADCC_ADDR_CTRL, `ADCC_CTRL_RESET);
        rd_chk(`ADCC_ADDR_MUX, `ADCC_MUX_RESET);
        // unmapped place: writes lost, reads zero
        wr_reg(8'h3c, 8'hff);
        rd_chk(8'h3c, 8'h00);
        rd_chk(`ADCC_ADDR_CTRL, 8'h00);
        for (int c = 0; c < 16; c++) begin
            v = 8'($random(seed));
            wr_reg(`ADCC_ADDR_MUX, {v[1:0], v[3], v[2], 4'(c)});
            repeat (2) @(posedge clk);
            #1;
            chk({vref_src, ext_ref_pin_en, analog_channel, analog_diff, analog_gain20, offset_cal, temp_sensor_en,
                bandgap_sel, ground_sel}, {exp_ref(v[2:0]), v[1:0] == 2'b01 || v[2:0] == 3'b111, 4'(c),
                exp_chan(4'(c))});
            rd_chk(`ADCC_ADDR_MUX, {v[1:0], v[3], v[2], 4'(c)});
        end
        @(posedge clk);
        global_irq_enable <= 1'b1;
        // temperature reading setup: 1.1V reference, sensor channel
        wr_reg(`ADCC_ADDR_MUX, 8'h8f);
        for (int p = 0; p < 8; p++) begin
            s = 10'($random(seed));
            @(posedge clk);
            sample_in <= s;
            wr_reg(`ADCC_ADDR_CTRL, 8'h00);
            wr_reg(`ADCC_ADDR_CTRL, 8'hc8 | 8'(p));
            wait_irq(n);
            rng(n, 25 * exp_div(3'(p)), exp_div(3'(p)));
            chk({4'h0, result_high, result_low}, {10'h0, s});
            wr_reg(`ADCC_ADDR_MUX, 8'haf);
            #1;
            chk({4'h0, result_high, result_low}, {4'h0, s, 6'h0});
            wr_reg(`ADCC_ADDR_MUX, 8'h8f);
            wr_reg(`ADCC_ADDR_CTRL, 8'h98 | 8'(p));
            rd_chk(`ADCC_ADDR_CTRL, 8'h88 | 8'(p));
            wr_reg(`ADCC_ADDR_CTRL, 8'hc8 | 8'(p));
            wait_irq(n);
            rng(n, 13 * exp_div(3'(p)), exp_div(3'(p)));
            ack();
            rd_chk(`ADCC_ADDR_CTRL, 8'h88 | 8'(p));
            chk({19'h0, irq}, 20'h0);
        end
        // selections written mid-conversion wait for completion
        wr_reg(`ADCC_ADDR_CTRL, 8'hc8);
        repeat (6) @(posedge clk);
        wr_reg(`ADCC_ADDR_MUX, 8'h43);
        rd_chk(`ADCC_ADDR_CTRL, 8'hc8);
        chk({16'(vref_src), analog_channel}, {16'(ADCC_REF_INT_1V1), 4'hf});
        wait_irq(n);
        #4;
        chk({15'(vref_src), ext_ref_pin_en, analog_channel}, {15'(ADCC_REF_EXTERNAL), 1'b1, 4'h3});
        wr_reg(`ADCC_ADDR_CTRL, 8'h98);
        wr_reg(`ADCC_ADDR_CTRL, 8'hc8);
        wait_irq(n);
        rng(n, 50, 2);
        @(posedge clk);
        global_irq_enable <= 1'b0;
        wr_reg(`ADCC_ADDR_CTRL, 8'h98);
        wr_reg(`ADCC_ADDR_CTRL, 8'hc8);
        repeat (60) @(posedge clk);
        rd_chk(`ADCC_ADDR_CTRL, 8'h98);
        chk({19'h0, irq}, 20'h0);
        global_irq_enable <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({19'h0, irq}, 20'h1);
        wr_reg(`ADCC_ADDR_CTRL, 8'h80);
        repeat (2) @(posedge clk);
        #1;
        chk({19'h0, irq}, 20'h0);
        rd_chk(`ADCC_ADDR_CTRL, 8'h90);
        // abort by disabling mid-conversion
        wr_reg(`ADCC_ADDR_CTRL, 8'hd8);
        repeat (10) @(posedge clk);
        wr_reg(`ADCC_ADDR_CTRL, 8'h08);
        repeat (100) @(posedge clk);
        #1;
        chk({19'h0, conv_power}, 20'h0);
        rd_chk(`ADCC_ADDR_CTRL, 8'h08);
        wr_reg(`ADCC_ADDR_CTRL, 8'h48);
        repeat (60) @(posedge clk);
        rd_chk(`ADCC_ADDR_CTRL, 8'h08);
        wr_reg(`ADCC_ADDR_CTRL, 8'h88);
        repeat (60) @(posedge clk);
        #1;
        chk({19'h0, conv_power}, 20'h1);
        rd_chk(`ADCC_ADDR_CTRL, 8'h88);
        // auto trigger on a rising edge, a held level triggers once
        wr_reg(`ADCC_ADDR_CTRL, 8'ha8);
        @(posedge clk);
        trigger_flag <= 1'b1;
        rd_chk(`ADCC_ADDR_CTRL, 8'he8);
        wait_irq(n);
        wr_reg(`ADCC_ADDR_CTRL, 8'hb8);
        repeat (60) @(posedge clk);
        rd_chk(`ADCC_ADDR_CTRL, 8'ha8);
        trigger_flag <= 1'b0;
        trigger_free_run <= 1'b1;
        repeat (60) @(posedge clk);
        rd_chk(`ADCC_ADDR_CTRL, 8'ha8);
        wr_reg(`ADCC_ADDR_CTRL, 8'he8);
        wait_irq(n);
        rd_chk(`ADCC_ADDR_CTRL, 8'hf8);
        ack();
        // irq lags the cleared flag by one edge; the relaunch lay six edges back
        @(posedge clk);
        wait_irq(n);
        rng(n + 6, 26, 2);
        wr_reg(`ADCC_ADDR_CTRL, 8'h00);
        results();
    end
endmodule : tb
